// [rtl/dfd_pkg.sv]
// constants, register map and field layout of the display fifo diagnostic access block
package dfd_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int DFD_ADDR_W = 16;
  localparam logic [15:0] DFD_GEN_CFG_OFF = 16'h8304;
  localparam logic [15:0] DFD_OUT_CFG_OFF = 16'h8308;
  localparam logic [15:0] DFD_DFIFO_OFF = 16'h8378;
  localparam logic [15:0] DFD_CFIFO_OFF = 16'h837C;
  localparam logic [15:0] DFD_STATUS_OFF = 16'h8380;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int DFD_GEN_LOAD_EN_BIT = 0;
  localparam int DFD_GEN_DIAGNOSTIC_SELECT_EN_BIT = 1;
  localparam int DFD_OUT_DIAGNOSTIC_SELECT_SEL_BIT = 0;
  localparam int DFD_OUT_CF_RW_BIT = 1;
  localparam logic [1:0] DFD_GEN_CFG_RST = 2'h1;
  localparam logic [1:0] DFD_OUT_CFG_RST = 2'h0;

  // ---------------------------------------------------------------
  // fifo geometry
  // ---------------------------------------------------------------
  localparam int DFD_DF_PTR_W = 4;
  localparam int DFD_DF_DEPTH = 16;
  localparam int DFD_CF_PTR_W = 4;
  localparam int DFD_CF_DEPTH = 16;

  // ---------------------------------------------------------------
  // bus responses
  // ---------------------------------------------------------------
  localparam logic [1:0] DFD_RESP_OKAY = 2'h0;
  localparam logic [1:0] DFD_RESP_SLVERR = 2'h2;

endpackage

// [rtl/dfd_fifo_diagnostic_select.sv]
// display and compressed fifo diagnostic access with an axi4-lite register slave
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
module dfd_fifo_diagnostic_select
  import dfd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [15:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic display_fetch_i,
  input wire logic compressed_fetch_i
);

  // ---------------------------------------------------------------
  // storage and state
  // ---------------------------------------------------------------
  logic [63:0] df_mem [DFD_DF_DEPTH];
  logic [31:0] cf_mem [DFD_CF_DEPTH];
  logic [DFD_DF_PTR_W-1:0] df_wptr_reg;
  logic [DFD_DF_PTR_W-1:0] df_rptr_reg;
  logic [DFD_CF_PTR_W-1:0] cf_wptr_reg;
  logic [DFD_CF_PTR_W-1:0] cf_rptr_reg;
  logic df_wr_half_reg;
  logic df_rd_half_reg;
  logic [31:0] df_low_reg;
  logic [31:0] df_latch_reg;
  logic [31:0] cf_latch_reg;
  logic [1:0] general_config_reg;
  logic [1:0] output_config_reg;
  logic [15:0] aw_addr_reg;
  logic aw_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_held_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0] rresp_next;
  logic [1:0] bresp_next;
  logic wr_fire;
  logic rd_fire;
  logic diagnostic_select_en;
  logic df_active;
  logic cf_active;
  logic cf_read_mode;
  logic df_wr;
  logic df_rd;
  logic cf_wr;
  logic cf_rd;

  function automatic logic mapped(input logic [15:0] a);
    mapped = (a == DFD_GEN_CFG_OFF) || (a == DFD_OUT_CFG_OFF) || (a == DFD_DFIFO_OFF) ||
             (a == DFD_CFIFO_OFF) || (a == DFD_STATUS_OFF);
  endfunction

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  assign diagnostic_select_en = general_config_reg[DFD_GEN_DIAGNOSTIC_SELECT_EN_BIT];
  assign df_active = diagnostic_select_en && !general_config_reg[DFD_GEN_LOAD_EN_BIT];
  assign cf_active = df_active && output_config_reg[DFD_OUT_DIAGNOSTIC_SELECT_SEL_BIT];
  assign cf_read_mode = output_config_reg[DFD_OUT_CF_RW_BIT];

  // ---------------------------------------------------------------
  // axi4-lite handshakes
  // ---------------------------------------------------------------
  assign s_axi_awready_o = !aw_held_reg;
  assign s_axi_wready_o = !w_held_reg;
  assign s_axi_arready_o = !rvalid_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign rd_fire = s_axi_arvalid_i && !rvalid_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign s_axi_rdata_o = rdata_reg;

  // fifo data registers sit at consecutive words
  assign df_wr = wr_fire && df_active && (aw_addr_reg == DFD_DFIFO_OFF);
  assign cf_wr = wr_fire && cf_active && !cf_read_mode && (aw_addr_reg == DFD_CFIFO_OFF);
  assign df_rd = rd_fire && df_active && (s_axi_araddr_i == DFD_DFIFO_OFF);
  assign cf_rd = rd_fire && cf_active && cf_read_mode && (s_axi_araddr_i == DFD_CFIFO_OFF);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 16'h0000;
    end else if (s_axi_awvalid_i && !aw_held_reg) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr_i;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid_i && !w_held_reg) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata_i;
      w_strb_reg <= s_axi_wstrb_i;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_comb begin
    bresp_next = mapped(aw_addr_reg) ? DFD_RESP_OKAY : DFD_RESP_SLVERR;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= DFD_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= bresp_next;
    end else if (s_axi_bready_i) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      general_config_reg <= DFD_GEN_CFG_RST;
      output_config_reg <= DFD_OUT_CFG_RST;
    end else if (wr_fire && w_strb_reg[0]) begin
      if (aw_addr_reg == DFD_GEN_CFG_OFF) begin
        general_config_reg <= w_data_reg[1:0];
      end
      if (aw_addr_reg == DFD_OUT_CFG_OFF) begin
        output_config_reg <= w_data_reg[1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // read data path
  // ---------------------------------------------------------------
  always_comb begin
    rdata_next = 32'h00000000;
    rresp_next = DFD_RESP_OKAY;
    if (s_axi_araddr_i == DFD_GEN_CFG_OFF) begin
      rdata_next = {30'h00000000, general_config_reg};
    end else if (s_axi_araddr_i == DFD_OUT_CFG_OFF) begin
      rdata_next = {30'h00000000, output_config_reg};
    end else if (s_axi_araddr_i == DFD_DFIFO_OFF) begin
      rdata_next = df_active ? df_latch_reg : 32'h00000000;
    end else if (s_axi_araddr_i == DFD_CFIFO_OFF) begin
      rdata_next = cf_rd ? cf_latch_reg : 32'h00000000;
    end else if (s_axi_araddr_i == DFD_STATUS_OFF) begin
      rdata_next = {14'h0000, df_rd_half_reg, df_wr_half_reg, cf_rptr_reg, cf_wptr_reg,
                    df_rptr_reg, df_wptr_reg};
    end else begin
      rresp_next = DFD_RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= DFD_RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end else if (s_axi_rready_i) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // display fifo: 64-bit entries written and read as 32-bit halves
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (df_wr && df_wr_half_reg) begin
      df_mem[df_wptr_reg] <= {w_data_reg, df_low_reg};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      df_wr_half_reg <= 1'b0;
      df_low_reg <= 32'h00000000;
      df_wptr_reg <= '0;
    end else if (df_wr) begin
      df_wr_half_reg <= !df_wr_half_reg;
      if (!df_wr_half_reg) begin
        df_low_reg <= w_data_reg;
      end else begin
        df_wptr_reg <= df_wptr_reg + 4'h1;
      end
    end
  end

  // each read returns the latch and refills it with the next half; the
  // shift finishes in one clock, well inside the spacing software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      df_rd_half_reg <= 1'b0;
      df_latch_reg <= 32'h00000000;
      df_rptr_reg <= '0;
    end else if (df_rd) begin
      df_rd_half_reg <= !df_rd_half_reg;
      if (!df_rd_half_reg) begin
        df_latch_reg <= df_mem[df_rptr_reg][31:0];
      end else begin
        df_latch_reg <= df_mem[df_rptr_reg][63:32];
        df_rptr_reg <= df_rptr_reg + 4'h1;
      end
    end else if (display_fetch_i && !diagnostic_select_en) begin
      df_rptr_reg <= df_rptr_reg + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // compressed data fifo: one word per access
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (cf_wr) begin
      cf_mem[cf_wptr_reg] <= w_data_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cf_wptr_reg <= '0;
    end else if (cf_wr) begin
      cf_wptr_reg <= cf_wptr_reg + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cf_latch_reg <= 32'h00000000;
      cf_rptr_reg <= '0;
    end else if (cf_rd) begin
      cf_latch_reg <= cf_mem[cf_rptr_reg];
      cf_rptr_reg <= cf_rptr_reg + 4'h1;
    end else if (compressed_fetch_i && !diagnostic_select_en) begin
      cf_rptr_reg <= cf_rptr_reg + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking dfd_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_dfifo_wptr_pair: assert property (df_wr && df_wr_half_reg |=>
      df_wptr_reg == $past(df_wptr_reg) + 4'h1)
    else $error("display write pointer did not advance on second write");

  a_dfifo_wptr_hold: assert property (df_wr && !df_wr_half_reg |=> $stable(df_wptr_reg))
    else $error("display write pointer moved on first half");

  a_dfifo_prime_data: assert property (df_rd |=> s_axi_rvalid_o &&
      s_axi_rdata_o == $past(df_latch_reg))
    else $error("display read did not return the latch");

  a_dfifo_half_order: assert property (df_rd && !df_rd_half_reg |=>
      df_latch_reg == df_mem[$past(df_rptr_reg)][31:0] ##0 df_rd_half_reg)
    else $error("display latch not loaded with low half");

  a_dfifo_rptr_pair: assert property (df_rd && df_rd_half_reg |=>
      df_rptr_reg == $past(df_rptr_reg) + 4'h1 && !df_rd_half_reg)
    else $error("display read pointer did not advance on second read");

  a_cfifo_wptr_step: assert property (cf_wr |=> cf_wptr_reg == $past(cf_wptr_reg) + 4'h1)
    else $error("compressed write pointer did not advance");

  a_cfifo_steer: assert property (rd_fire && !cf_read_mode |=> $stable(cf_rptr_reg))
    else $error("compressed read pointer moved while in write mode");

  a_cfifo_read_data: assert property (cf_rd |=> s_axi_rdata_o == $past(cf_latch_reg)
      && cf_latch_reg == cf_mem[$past(cf_rptr_reg)])
    else $error("compressed read returned wrong word");

  a_cfifo_rptr_step: assert property (cf_rd |=> cf_rptr_reg == $past(cf_rptr_reg) + 4'h1)
    else $error("compressed read pointer did not advance");

  a_map_decode: assert property (rd_fire && !mapped(s_axi_araddr_i) |=>
      s_axi_rvalid_o && s_axi_rresp_o == DFD_RESP_SLVERR)
    else $error("unmapped read not refused");

  a_refresh_frozen: assert property (diagnostic_select_en && !df_rd && !cf_rd |=>
      $stable(df_rptr_reg) && $stable(cf_rptr_reg))
    else $error("refresh fetch moved a pointer during diagnostic access");

  c_dfifo_pair_write: cover property (df_wr && df_wr_half_reg);
  c_dfifo_pair_read: cover property (df_rd && df_rd_half_reg);
  c_cfifo_read: cover property (cf_rd ##[1:20] cf_rd);
  c_unmapped: cover property (wr_fire && !mapped(aw_addr_reg));

endmodule

// [testbench/tb.sv]
// self-checking bench for the fifo diagnostic access block over axi4-lite
`timescale 1ns/1ps
module tb;
  import dfd_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic [15:0] awaddr = 16'h0, araddr = 16'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic dfetch = 1'b0, cfetch = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, last_resp;
  logic [31:0] rdata, d;
  int mismatches = 0, n_compared = 0;
  // one spare entry beyond what is read back, so the prefetch on the last read finds data
  logic [31:0] dw [6] = '{32'hA5A50001, 32'h5A5A0002, 32'hC3C30003, 32'h3C3C0004,
    32'h96960008, 32'h69690009};
  logic [31:0] cw [4] = '{32'h11110005, 32'h22220006, 32'h33330007, 32'h4444000A};

  dfd_fifo_diagnostic_select dut_u (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .display_fetch_i(dfetch), .compressed_fetch_i(cfetch));

  initial begin
    forever #2 clk_i = ~clk_i;
  end
  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  // ready is sampled mid-cycle, so it equals what the next rising edge sees
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    logic a1, w1, b1;
    repeat (4) @(posedge clk_i);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b1 = 1'b0;
    while (!b1) begin
      @(negedge clk_i);
      a1 = awvalid && awready;
      w1 = wvalid && wready;
      b1 = bready && (bvalid === 1'b1);
      last_resp = bresp;
      @(posedge clk_i);
      if (a1) awvalid <= 1'b0;
      if (w1) wvalid <= 1'b0;
      if (b1) bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] v);
    logic a1, r1;
    repeat (4) @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r1 = 1'b0;
    while (!r1) begin
      @(negedge clk_i);
      a1 = arvalid && arready;
      r1 = rready && (rvalid === 1'b1);
      v = rdata;
      last_resp = rresp;
      @(posedge clk_i);
      if (a1) arvalid <= 1'b0;
      if (r1) rready <= 1'b0;
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic fetch_pulse();
    @(posedge clk_i);
    dfetch <= 1'b1;
    cfetch <= 1'b1;
    @(posedge clk_i);
    dfetch <= 1'b0;
    cfetch <= 1'b0;
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(DFD_GEN_CFG_OFF, d); chk(d, 32'h00000001);
    rd(DFD_OUT_CFG_OFF, d); chk(d, 32'h00000000);
    rd(DFD_STATUS_OFF, d); chk(d, 32'h00000000);
    rd(16'h8390, d); chk({30'h0, last_resp}, {30'h0, DFD_RESP_SLVERR});
    chk(d, 32'h00000000);
    wr(16'h8390, 32'h1); chk({30'h0, last_resp}, {30'h0, DFD_RESP_SLVERR});
    // load enable still set: display fifo must stay closed
    wr(DFD_DFIFO_OFF, 32'hDEAD0000); chk({30'h0, last_resp}, 32'h0);
    rd(DFD_DFIFO_OFF, d); chk(d, 32'h00000000);
    rd(DFD_STATUS_OFF, d); chk(d, 32'h00000000);
    // display fifo: two writes per entry, spaced by the tasks
    wr(DFD_GEN_CFG_OFF, 32'h00000002);
    wr(DFD_DFIFO_OFF, dw[0]);
    rd(DFD_STATUS_OFF, d); chk(d, 32'h00010000);
    wr(DFD_DFIFO_OFF, dw[1]);
    rd(DFD_STATUS_OFF, d); chk(d, 32'h00000001);
    for (int i = 2; i < 6; i++) begin
      wr(DFD_DFIFO_OFF, dw[i]);
    end
    rd(DFD_DFIFO_OFF, d);
    rd(DFD_STATUS_OFF, d); chk(d & 32'hFFFF, 32'h0003);
    for (int i = 0; i < 4; i++) begin
      rd(DFD_DFIFO_OFF, d); chk(d, dw[i]);
      rd(DFD_STATUS_OFF, d); chk(d & 32'hFFFF, 32'h0003 | (((i + 2) / 2) << 4));
    end
    // refresh fetches are ignored while diagnostic access is on
    fetch_pulse();
    rd(DFD_STATUS_OFF, d); chk(d & 32'hFFFF, 32'h0023);
    // compressed fifo: one word per entry
    wr(DFD_OUT_CFG_OFF, 32'h00000001);
    for (int i = 0; i < 4; i++) begin
      wr(DFD_CFIFO_OFF, cw[i]);
      rd(DFD_STATUS_OFF, d); chk(d & 32'hFFFF, 32'h0023 | ((i + 1) << 8));
    end
    wr(DFD_OUT_CFG_OFF, 32'h00000003);
    rd(DFD_CFIFO_OFF, d);
    rd(DFD_STATUS_OFF, d); chk(d & 32'hFFFF, 32'h1423);
    for (int i = 0; i < 3; i++) begin
      rd(DFD_CFIFO_OFF, d); chk(d, cw[i]);
      rd(DFD_STATUS_OFF, d); chk(d & 32'hFFFF, 32'h1423 + ((i + 1) << 12));
    end
    fetch_pulse();
    rd(DFD_STATUS_OFF, d); chk(d & 32'hFFFF, 32'h4423);
    // diagnostic off: refresh pops advance both read pointers
    wr(DFD_GEN_CFG_OFF, 32'h00000001);
    fetch_pulse();
    rd(DFD_STATUS_OFF, d); chk(d & 32'hFFFF, 32'h5433);
    conclude();
  end

  initial begin
    #20000;
    mismatches++;
    conclude();
  end
endmodule
